/* bkc_consts.svh */
`ifndef BKC_CONSTS_SVH
`define BKC_CONSTS_SVH

// -----------------------------------------------------------------
// register map
// -----------------------------------------------------------------
`define BKC_OFS_BANK0 8'h00
`define BKC_OFS_BANK1 8'h01
`define BKC_OFS_CTRL 8'h02

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define BKC_SW_EN_BIT 7
`define BKC_PWM_BIT 6
`define BKC_CODE_MSB 5
`define BKC_DISC_BIT 7
`define BKC_SLEW_MSB 6
`define BKC_SLEW_LSB 4
`define BKC_SOFT_RST_BIT 2

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define BKC_BANK_RST 8'h97
`define BKC_DISC_RST 1'h1
`define BKC_SLEW_RST 3'h0

// -----------------------------------------------------------------
// slave addresses of the two variants
// -----------------------------------------------------------------
`define BKC_ADDR_VAR0 7'h40
`define BKC_ADDR_VAR1 7'h41

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define BKC_OVP_BLANK_NS 20000
`define BKC_CORE_PERIOD_PS 4000

`endif

/* bkc_pkg.sv */
package bkc_pkg;

	// register contents that the regulator core consumes
	typedef struct packed {
		logic [7:0] bank0; // enable, force pwm, code of bank zero
		logic [7:0] bank1; // enable, force pwm, code of bank one
		logic disc; // output discharge enable
		logic [2:0] slew; // rising slew interval code
	} bkc_regs_t;

	// serial slave states, gray coded along the write path
	typedef enum logic [3:0] {
		BKC_IDLE = 4'h0,
		BKC_ADDR = 4'h1,
		BKC_AACK = 4'h3,
		BKC_REGA = 4'h2,
		BKC_RACK = 4'h6,
		BKC_WDAT = 4'h7,
		BKC_WACK = 4'h5,
		BKC_RDAT = 4'h4,
		BKC_MACK = 4'hC
	} bkc_state_t;

endpackage : bkc_pkg

/* bkc_buck_ctrl.sv */
// How it works
// R1 - enable pin low forces output off
// R2 - enable pin rising launches power-up
// R3 - output follows selected bank bit 7
// R4 - both software enables reset to one
// R5 - over-voltage past 20us stops switching
// R6 - serial slave only, up to 3.4MHz
// R7 - first byte: address then direction
// R8 - answers 1000000x or 1000001x per variant
// R9 - matching address acknowledged on ninth pulse
// R10 - mismatch leaves data released, not acknowledged
// R11 - second byte selects target register
// R12 - receiver of each byte acknowledges it
// R13 - start and stop seen while clock high
// R14 - master makes start and stop
// R15 - data changes only while clock low
// R16 - bank bit 6 forces pwm, reset 0
// R17 - bank bits 5:0 code, reset 010111
// R18 - select pin low bank0, high bank1
// R19 - control bit 7 discharge, reset one
// R20 - control bits 6:4 slew code, reset 000
// R21 - control bit 2 restores all defaults
// R22 - reserved control bits read zero
// R23 - written data bytes stored and acknowledged
// R24 - read bytes shifted msb first
`timescale 1ns/1ps
`include "bkc_consts.svh"

module bkc_buck_ctrl
	import bkc_pkg::*;
#(
	parameter bit ADDR_VARIANT = 1'b0,
	parameter int OVP_BLANK_CYCLES =
		(`BKC_OVP_BLANK_NS * 1000 + `BKC_CORE_PERIOD_PS - 1) / `BKC_CORE_PERIOD_PS
) (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic LINK_CLK,
	input wire logic SCL,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE,
	input wire logic EN_PIN,
	input wire logic BANK_SELECT_PIN,
	input wire logic OVP_IN,
	output logic OUT_ON,
	output logic POWERUP_START,
	output logic FORCE_PWM,
	output logic [5:0] VOUT_CODE,
	output logic DISCHARGE_EN,
	output logic [2:0] SLEW_CODE,
	output logic OVP_TRIP
);

	// -----------------------------------------------------------------
	// link side: pin synchronisers
	// -----------------------------------------------------------------
	logic scl_s1, scl_s, scl_p; // clock pin: sync pair and previous
	logic sda_s1, sda_s, sda_p; // data pin: sync pair and previous
	logic [6:0] own_addr; // variant address

	assign own_addr = ADDR_VARIANT ? `BKC_ADDR_VAR1 : `BKC_ADDR_VAR0; // [R8]

	// oversampling lets the slave follow a 3.4MHz bus from the fast link clock
	always_ff @(posedge LINK_CLK or posedge RST) begin // [R6]
		if (RST) begin
			scl_s1 <= 1'b1;
			scl_s <= 1'b1;
			scl_p <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s <= 1'b1;
			sda_p <= 1'b1;
		end else begin
			scl_s1 <= SCL;
			scl_s <= scl_s1;
			scl_p <= scl_s;
			sda_s1 <= SDA_I;
			sda_s <= sda_s1;
			sda_p <= sda_s;
		end
	end

	// -----------------------------------------------------------------
	// link side: bus conditions
	// -----------------------------------------------------------------
	logic scl_rise, scl_fall, bus_start, bus_stop;

	assign scl_rise = scl_s & ~scl_p;
	assign scl_fall = ~scl_s & scl_p;
	// data moving while clock stays high is a condition, never a data bit
	assign bus_start = scl_s & scl_p & sda_p & ~sda_s; // [R13] [R15]
	assign bus_stop = scl_s & scl_p & ~sda_p & sda_s; // [R13] [R15]

	// -----------------------------------------------------------------
	// link side: slave state machine and registers
	// -----------------------------------------------------------------
	bkc_state_t st_q, st_d; // protocol state
	logic [3:0] cnt_q, cnt_d; // bits of the current byte
	logic [7:0] sh_q, sh_d; // shift register
	logic [7:0] ptr_q, ptr_d; // register pointer
	logic rw_q, rw_d; // direction of this transfer
	logic nack_q, nack_d; // master answer after a read byte
	logic oe_q, oe_d; // pull data low
	logic wr_ev; // a register was written
	bkc_regs_t regs_q, regs_d; // register file
	bkc_regs_t regs_def; // default register values

	assign regs_def = '{bank0: `BKC_BANK_RST, bank1: `BKC_BANK_RST, // [R4] [R16] [R17]
		disc: `BKC_DISC_RST, slew: `BKC_SLEW_RST}; // [R19] [R20]

	// read view; unmapped pointers and reserved bits give zero
	function automatic logic [7:0] rd_val(input logic [7:0] p, input bkc_regs_t r);
		logic [7:0] v;
		v = 8'h00;
		case (p)
			`BKC_OFS_BANK0: v = r.bank0;
			`BKC_OFS_BANK1: v = r.bank1;
			`BKC_OFS_CTRL: v = {r.disc, r.slew, 4'h0}; // [R22]
			default: v = 8'h00;
		endcase
		return v;
	endfunction : rd_val

	// next state of the serial slave
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		ptr_d = ptr_q;
		rw_d = rw_q;
		nack_d = nack_q;
		oe_d = oe_q;
		regs_d = regs_q;
		wr_ev = 1'b0;
		if (bus_start) begin
			// a start anywhere restarts address reception
			st_d = BKC_ADDR; // [R13]
			cnt_d = 4'h0;
			oe_d = 1'b0;
		end else if (bus_stop) begin
			st_d = BKC_IDLE; // [R13]
			oe_d = 1'b0;
		end else begin
			case (st_q)
				BKC_IDLE: begin
					oe_d = 1'b0;
				end
				BKC_ADDR, BKC_REGA, BKC_WDAT: begin
					// sample on rising clock, act after the eighth bit
					if (scl_rise) begin
						sh_d = {sh_q[6:0], sda_s};
						cnt_d = cnt_q + 4'h1;
					end
					if (scl_fall && cnt_q == 4'h8) begin
						cnt_d = 4'h0;
						if (st_q == BKC_ADDR) begin
							rw_d = sh_q[0]; // [R7]
							if (sh_q[7:1] == own_addr) begin // [R8]
								st_d = BKC_AACK;
								oe_d = 1'b1; // [R9]
							end else begin
								st_d = BKC_IDLE;
								oe_d = 1'b0; // [R10]
							end
						end else if (st_q == BKC_REGA) begin
							ptr_d = sh_q; // [R11]
							st_d = BKC_RACK;
							oe_d = 1'b1; // [R12]
						end else begin
							// store the byte and step to the next register
							case (ptr_q) // [R23]
								`BKC_OFS_BANK0: regs_d.bank0 = sh_q;
								`BKC_OFS_BANK1: regs_d.bank1 = sh_q;
								`BKC_OFS_CTRL: begin
									if (sh_q[`BKC_SOFT_RST_BIT]) begin
										regs_d = regs_def; // [R21]
									end else begin
										regs_d.disc = sh_q[`BKC_DISC_BIT]; // [R19]
										regs_d.slew = sh_q[`BKC_SLEW_MSB:`BKC_SLEW_LSB]; // [R20]
									end
								end
								default: regs_d = regs_q;
							endcase
							wr_ev = 1'b1;
							ptr_d = ptr_q + 8'h01;
							st_d = BKC_WACK;
							oe_d = 1'b1; // [R12] [R23]
						end
					end
				end
				BKC_AACK, BKC_RACK, BKC_WACK: begin
					// release after the ninth pulse
					if (scl_fall) begin
						oe_d = 1'b0;
						cnt_d = 4'h0;
						if (st_q == BKC_AACK && rw_q) begin
							sh_d = rd_val(ptr_q, regs_q); // [R24]
							oe_d = ~sh_d[7];
							ptr_d = ptr_q + 8'h01;
							st_d = BKC_RDAT;
						end else if (st_q == BKC_AACK) begin
							st_d = BKC_REGA; // [R11]
						end else begin
							st_d = BKC_WDAT;
						end
					end
				end
				BKC_RDAT: begin
					// msb was placed at load, later bits on each falling clock
					if (scl_rise) begin
						cnt_d = cnt_q + 4'h1;
					end
					if (scl_fall) begin
						if (cnt_q == 4'h8) begin
							oe_d = 1'b0; // [R24]
							st_d = BKC_MACK;
						end else begin
							sh_d = {sh_q[6:0], 1'b0};
							oe_d = ~sh_q[6]; // [R24]
						end
					end
				end
				BKC_MACK: begin
					if (scl_rise) begin
						nack_d = sda_s; // [R12]
					end
					if (scl_fall) begin
						if (!nack_q) begin
							sh_d = rd_val(ptr_q, regs_q);
							oe_d = ~sh_d[7];
							ptr_d = ptr_q + 8'h01;
							cnt_d = 4'h0;
							st_d = BKC_RDAT;
						end else begin
							st_d = BKC_IDLE;
						end
					end
				end
				default: begin
					st_d = BKC_IDLE;
					oe_d = 1'b0;
				end
			endcase
		end
	end

	// slave registers
	always_ff @(posedge LINK_CLK or posedge RST) begin
		if (RST) begin
			st_q <= BKC_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			ptr_q <= 8'h00;
			rw_q <= 1'b0;
			nack_q <= 1'b1;
			oe_q <= 1'b0;
			regs_q <= '{bank0: `BKC_BANK_RST, bank1: `BKC_BANK_RST, // [R4]
				disc: `BKC_DISC_RST, slew: `BKC_SLEW_RST};
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			ptr_q <= ptr_d;
			rw_q <= rw_d;
			nack_q <= nack_d;
			oe_q <= oe_d;
			regs_q <= regs_d;
		end
	end

	// open drain: only ever pulls low
	assign SDA_OE = oe_q;
	assign SDA_O = 1'b0;

	// -----------------------------------------------------------------
	// crossing: toggle handshake carries a register snapshot to the core
	// -----------------------------------------------------------------
	logic xreq_q, xreq_d; // request toggle, link side
	logic pend_q, pend_d; // registers changed since last snapshot
	logic ack_s1, ack_s2; // acknowledge toggle synchronised
	logic launch; // send a new snapshot now
	logic rseen_q, rseen_d; // last request taken, core side, fed back as acknowledge
	bkc_regs_t xhold_q, xhold_d; // held stable while a request is open

	assign launch = pend_q & (xreq_q == ack_s2);

	// a write that lands while a snapshot is sent stays pending
	always_comb begin
		pend_d = (pend_q & ~launch) | wr_ev;
		xreq_d = launch ? ~xreq_q : xreq_q;
		xhold_d = launch ? regs_q : xhold_q;
	end

	always_ff @(posedge LINK_CLK or posedge RST) begin
		if (RST) begin
			pend_q <= 1'b0;
			xreq_q <= 1'b0;
			xhold_q <= '{bank0: `BKC_BANK_RST, bank1: `BKC_BANK_RST,
				disc: `BKC_DISC_RST, slew: `BKC_SLEW_RST};
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
		end else begin
			pend_q <= pend_d;
			xreq_q <= xreq_d;
			xhold_q <= xhold_d;
			ack_s1 <= rseen_q;
			ack_s2 <= ack_s1;
		end
	end

	// -----------------------------------------------------------------
	// core side: synchronisers and snapshot capture
	// -----------------------------------------------------------------
	logic rq_s1, rq_s2; // request toggle synchronised
	logic en_s1, en_s, en_p; // enable pin
	logic sel_s1, sel_s; // bank select pin
	logic ovp_s1, ovp_s; // over-voltage indication
	bkc_regs_t cregs_q, cregs_d; // core copy of the registers

	// snapshot is only read after its toggle arrived, so it is stable
	always_comb begin
		rseen_d = rq_s2;
		cregs_d = (rq_s2 != rseen_q) ? xhold_q : cregs_q;
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			rq_s1 <= 1'b0;
			rq_s2 <= 1'b0;
			rseen_q <= 1'b0;
			cregs_q <= '{bank0: `BKC_BANK_RST, bank1: `BKC_BANK_RST,
				disc: `BKC_DISC_RST, slew: `BKC_SLEW_RST};
			en_s1 <= 1'b0;
			en_s <= 1'b0;
			en_p <= 1'b0;
			sel_s1 <= 1'b0;
			sel_s <= 1'b0;
			ovp_s1 <= 1'b0;
			ovp_s <= 1'b0;
		end else begin
			rq_s1 <= xreq_q;
			rq_s2 <= rq_s1;
			rseen_q <= rseen_d;
			cregs_q <= cregs_d;
			en_s1 <= EN_PIN;
			en_s <= en_s1;
			en_p <= en_s;
			sel_s1 <= BANK_SELECT_PIN;
			sel_s <= sel_s1;
			ovp_s1 <= OVP_IN;
			ovp_s <= ovp_s1;
		end
	end

	// -----------------------------------------------------------------
	// core side: enable, bank choice and over-voltage blanking
	// -----------------------------------------------------------------
	logic [15:0] ovp_cnt_q, ovp_cnt_d; // time the indication has stood
	logic [7:0] bank; // bank chosen by the select pin
	logic on_q, on_d, pup_q, pup_d, trip_q, trip_d;
	logic pwm_q, pwm_d, disc_q, disc_d;
	logic [5:0] code_q, code_d;
	logic [2:0] slew_q, slew_d;

	always_comb begin
		bank = sel_s ? cregs_q.bank1 : cregs_q.bank0; // [R18]
		// spikes shorter than the blanking time reset the count
		if (!ovp_s) begin
			ovp_cnt_d = 16'h0000;
		end else if (ovp_cnt_q == 16'(OVP_BLANK_CYCLES)) begin
			ovp_cnt_d = ovp_cnt_q;
		end else begin
			ovp_cnt_d = ovp_cnt_q + 16'h0001;
		end
		trip_d = (ovp_cnt_d == 16'(OVP_BLANK_CYCLES)); // [R5]
		on_d = en_s & bank[`BKC_SW_EN_BIT] & ~trip_q; // [R1] [R3]
		pup_d = en_s & ~en_p; // [R2]
		pwm_d = bank[`BKC_PWM_BIT]; // [R16]
		code_d = bank[`BKC_CODE_MSB:0]; // [R17]
		disc_d = cregs_q.disc; // [R19]
		slew_d = cregs_q.slew; // [R20]
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			ovp_cnt_q <= 16'h0000;
			trip_q <= 1'b0;
			on_q <= 1'b0;
			pup_q <= 1'b0;
			pwm_q <= 1'b0;
			code_q <= 6'h17;
			disc_q <= `BKC_DISC_RST;
			slew_q <= `BKC_SLEW_RST;
		end else begin
			ovp_cnt_q <= ovp_cnt_d;
			trip_q <= trip_d;
			on_q <= on_d;
			pup_q <= pup_d;
			pwm_q <= pwm_d;
			code_q <= code_d;
			disc_q <= disc_d;
			slew_q <= slew_d;
		end
	end

	assign OUT_ON = on_q;
	assign POWERUP_START = pup_q;
	assign OVP_TRIP = trip_q;
	assign FORCE_PWM = pwm_q;
	assign VOUT_CODE = code_q;
	assign DISCHARGE_EN = disc_q;
	assign SLEW_CODE = slew_q;

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	sequence s_pulse_once;
		POWERUP_START ##1 !POWERUP_START;
	endsequence

	property p_en_off;
		@(posedge CORE_CLK) disable iff (RST) !en_s |=> !OUT_ON;
	endproperty
	a_en_off: assert property (p_en_off) else $error("output on with enable low"); // [R1]

	property p_powerup;
		@(posedge CORE_CLK) disable iff (RST) $rose(en_s) |=> s_pulse_once;
	endproperty
	a_powerup: assert property (p_powerup) else $error("no single power-up pulse"); // [R2]

	property p_bank_on;
		@(posedge CORE_CLK) disable iff (RST) (en_s && !trip_q) |=>
			OUT_ON == ($past(sel_s) ? $past(cregs_q.bank1[7]) : $past(cregs_q.bank0[7]));
	endproperty
	a_bank_on: assert property (p_bank_on) else $error("output not from chosen bank"); // [R3]

	property p_ovp;
		@(posedge CORE_CLK) disable iff (RST)
			// the output register follows the trip flag one cycle later
			OVP_TRIP |-> ($past(ovp_s) && ovp_cnt_q == 16'(OVP_BLANK_CYCLES)) ##1 !OUT_ON;
	endproperty
	a_ovp: assert property (p_ovp) else $error("trip before blanking time"); // [R5]

	property p_addr_ack;
		@(posedge LINK_CLK) disable iff (RST)
			(st_q == BKC_ADDR && scl_fall && cnt_q == 4'h8 && !bus_start && !bus_stop &&
			sh_q[7:1] == own_addr) |=> (SDA_OE && st_q == BKC_AACK);
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("own address not acked"); // [R9]

	property p_addr_nack;
		@(posedge LINK_CLK) disable iff (RST)
			(st_q == BKC_ADDR && scl_fall && cnt_q == 4'h8 && sh_q[7:1] != own_addr)
			|=> !SDA_OE;
	endproperty
	a_addr_nack: assert property (p_addr_nack) else $error("foreign address acked"); // [R10]

	property p_start;
		@(posedge LINK_CLK) disable iff (RST) bus_start |=> (st_q == BKC_ADDR && !SDA_OE);
	endproperty
	a_start: assert property (p_start) else $error("start not taken"); // [R13]

	property p_soft_rst;
		@(posedge LINK_CLK) disable iff (RST)
			(wr_ev && ptr_q == `BKC_OFS_CTRL && sh_q[`BKC_SOFT_RST_BIT])
			|=> (regs_q == regs_def);
	endproperty
	a_soft_rst: assert property (p_soft_rst) else $error("soft reset missed"); // [R21]

	property p_write;
		@(posedge LINK_CLK) disable iff (RST)
			(wr_ev && ptr_q == `BKC_OFS_BANK1) |=> (regs_q.bank1 == $past(sh_q) && SDA_OE);
	endproperty
	a_write: assert property (p_write) else $error("write not stored"); // [R23]

endmodule : bkc_buck_ctrl

/* bkc_host_master.sv */
`timescale 1ns/1ps

// host side of the serial link: a behavioural bus master driven by tasks
module bkc_host_master
	import bkc_pkg::*;
(
	input wire logic sda, // wire level, pull-up applied outside
	output logic scl, // bus clock, stands high between frames
	output logic sda_pull // high while the master pulls data low
);
	// -----------------------------------------------------------------
	// bit timing
	// -----------------------------------------------------------------
	// quarter bit; four of them give about 3.33 MHz, just under the top rate
	localparam int T_Q = 75;
	logic busy_q; // a frame is open

	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
		busy_q = 1'b0;
	end

	// -----------------------------------------------------------------
	// conditions and bits
	// -----------------------------------------------------------------
	// start: data falls while the clock is high
	task automatic bus_start();
		if (busy_q) begin
			bus_stop(); // never a start on an open frame
		end
		#(T_Q);
		sda_pull = 1'b1;
		#(T_Q);
		scl = 1'b0;
		busy_q = 1'b1;
	endtask : bus_start

	// stop: data rises while the clock is high
	task automatic bus_stop();
		#(T_Q);
		sda_pull = 1'b1;
		#(T_Q);
		scl = 1'b1;
		#(T_Q);
		sda_pull = 1'b0;
		#(T_Q);
		busy_q = 1'b0;
	endtask : bus_stop

	// data moves a quarter after the clock falls, so it never races the fall
	task automatic bus_bit(input logic b, output logic got);
		#(T_Q);
		sda_pull = ~b; // changes only while the clock is low
		#(T_Q);
		scl = 1'b1;
		#(T_Q);
		got = sda;
		#(T_Q);
		scl = 1'b0;
	endtask : bus_bit

	// -----------------------------------------------------------------
	// bytes and transfers
	// -----------------------------------------------------------------
	// eight bits msb first, then the line released for the receiver's ack
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic unused;
		for (int i = 7; i >= 0; i--) begin
			bus_bit(d[i], unused);
		end
		bus_bit(1'b1, ack);
	endtask : send_byte

	// the master acks every read byte but the last one
	task automatic recv_byte(input logic last, output logic [7:0] d);
		logic unused;
		for (int i = 7; i >= 0; i--) begin
			bus_bit(1'b1, d[i]);
		end
		bus_bit(last, unused);
	endtask : recv_byte

	// acks come back raw: 0 means acknowledged
	task automatic write_reg(input logic [6:0] dev, input logic [7:0] ra,
		input logic [7:0] d, output logic [2:0] acks);
		bus_start();
		send_byte({dev, 1'b0}, acks[2]); // direction 0 writes
		send_byte(ra, acks[1]);
		send_byte(d, acks[0]);
		bus_stop();
	endtask : write_reg

	// pointer set by a write frame, then a separate read frame
	task automatic read_reg(input logic [6:0] dev, input logic [7:0] ra,
		output logic [7:0] d, output logic [2:0] acks);
		bus_start();
		send_byte({dev, 1'b0}, acks[2]);
		send_byte(ra, acks[1]);
		bus_stop();
		bus_start();
		send_byte({dev, 1'b1}, acks[0]); // direction 1 reads
		recv_byte(1'b1, d);
		bus_stop();
	endtask : read_reg

	// burst read: the master acks the first byte, so the pointer steps on
	task automatic read_two(input logic [6:0] dev, input logic [7:0] ra,
		output logic [15:0] d, output logic [2:0] acks);
		bus_start();
		send_byte({dev, 1'b0}, acks[2]);
		send_byte(ra, acks[1]);
		bus_stop();
		bus_start();
		send_byte({dev, 1'b1}, acks[0]);
		recv_byte(1'b0, d[15:8]);
		recv_byte(1'b1, d[7:0]);
		bus_stop();
	endtask : read_two

endmodule : bkc_host_master

/* tb_top.sv */
`timescale 1ns/1ps
`include "bkc_consts.svh"

module tb_top
	import bkc_pkg::*;
;
	// -----------------------------------------------------------------
	// signals
	// -----------------------------------------------------------------
	localparam int TIMEOUT = 95000; // core cycles; the run needs about 66000
	logic core_clk, link_clk, rst, en_pin, bank_sel, ovp_in;
	logic scl, sda_w, sda_oe, m_pull;
	logic out_on, powerup_start, force_pwm, discharge_en, ovp_trip;
	logic [5:0] vout_code;
	logic [2:0] slew_code;
	int failures = 0;
	int n_tests = 0;
	int cycles = 0;
	int seed = 32'h334b;

	// open drain wire with pull-up: low if either party pulls
	assign sda_w = (sda_oe | m_pull) ? 1'b0 : 1'b1;

	bkc_buck_ctrl #(.ADDR_VARIANT(1'b0), .OVP_BLANK_CYCLES(20)) bkc_buck_ctrl_inst (
		.CORE_CLK(core_clk), .RST(rst), .LINK_CLK(link_clk), .SCL(scl), .SDA_I(sda_w),
		.SDA_O(), .SDA_OE(sda_oe), .EN_PIN(en_pin), .BANK_SELECT_PIN(bank_sel),
		.OVP_IN(ovp_in), .OUT_ON(out_on), .POWERUP_START(powerup_start),
		.FORCE_PWM(force_pwm), .VOUT_CODE(vout_code), .DISCHARGE_EN(discharge_en),
		.SLEW_CODE(slew_code), .OVP_TRIP(ovp_trip));

	bkc_host_master bkc_host_master_inst (.sda(sda_w), .scl(scl), .sda_pull(m_pull));

	// -----------------------------------------------------------------
	// clocks and timeout
	// -----------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// link clock offset so the two never line up
	initial begin
		link_clk = 1'b0;
		#1.3;
		forever #3 link_clk = ~link_clk;
	end

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == TIMEOUT) begin
			failures++;
			$display("[ERR] %0t run hung", $time);
			test_done();
		end
	end

	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	// pins move one ns after a core edge
	task automatic drive_pins(input logic en, input logic sel, input logic ovp);
		@(posedge core_clk);
		#1;
		en_pin = en;
		bank_sel = sel;
		ovp_in = ovp;
	endtask : drive_pins

	// or of trip and power-up pulse over n cycles
	task automatic watch(input int n, output logic t, output logic p);
		t = 1'b0;
		p = 1'b0;
		repeat (n) begin
			@(posedge core_clk);
			#1;
			t = t | ovp_trip;
			p = p | powerup_start;
		end
	endtask : watch

	function automatic logic exp_on(logic en, logic sel, logic [7:0] b0, logic [7:0] b1);
		return en & (sel ? b1[7] : b0[7]);
	endfunction : exp_on

	// reserved nibble and soft reset bit read zero
	function automatic logic [7:0] exp_ctrl(logic [7:0] d);
		return {d[7:4], 4'h0};
	endfunction : exp_ctrl

	// core outputs follow the selected bank once the pins settle
	task automatic check_core(input logic [7:0] b0, input logic [7:0] b1);
		logic [7:0] s;
		s = bank_sel ? b1 : b0;
		repeat (12) @(posedge core_clk);
		#1;
		check({2'h0, vout_code}, {2'h0, s[5:0]}, "vout code");
		check({7'h0, force_pwm}, {7'h0, s[6]}, "force pwm");
		check({7'h0, out_on}, {7'h0, exp_on(en_pin, bank_sel, b0, b1)}, "on");
	endtask : check_core

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : test_done

	// -----------------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------------
	initial begin
		logic [7:0] d, b0, b1;
		logic [2:0] acks;
		logic [15:0] w; // burst read result
		logic t, p;
		rst = 1'b1;
		en_pin = 1'b1;
		bank_sel = 1'b0;
		ovp_in = 1'b0;
		repeat (8) @(posedge core_clk);
		#1;
		rst = 1'b0;
		repeat (10) @(posedge core_clk);
		// defaults of all three registers
		b0 = `BKC_BANK_RST;
		b1 = `BKC_BANK_RST;
		for (int i = 0; i < 3; i++) begin
			bkc_host_master_inst.read_reg(`BKC_ADDR_VAR0, i[7:0], d, acks);
			check({5'h0, acks}, 8'h00, "acks");
			check(d, (i == 2) ? 8'h80 : `BKC_BANK_RST, "default");
		end
		check({7'h0, discharge_en}, 8'h01, "discharge");
		check({5'h0, slew_code}, 8'h00, "slew");
		check_core(b0, b1);
		$display("reset values done");
		// the other variant's address is refused and nothing is stored
		bkc_host_master_inst.write_reg(`BKC_ADDR_VAR1, `BKC_OFS_BANK0, 8'h00, acks);
		check({5'h0, acks}, 8'h07, "foreign acks");
		bkc_host_master_inst.read_reg(`BKC_ADDR_VAR0, `BKC_OFS_BANK0, d, acks);
		check(d, b0, "bank0 kept");
		$display("address match done");
		// bank writes: code ends first, then random values
		for (int it = 0; it < 4; it++) begin
			d = (it == 0) ? 8'h40 : (it == 1) ? 8'hBF : 8'($random(seed));
			if (it[0]) begin
				b1 = d;
			end else begin
				b0 = d;
			end
			bkc_host_master_inst.write_reg(`BKC_ADDR_VAR0, {7'h0, it[0]}, d, acks);
			check({5'h0, acks}, 8'h00, "write acks");
			bkc_host_master_inst.read_reg(`BKC_ADDR_VAR0, {7'h0, it[0]}, d, acks);
			check(d, it[0] ? b1 : b0, "readback");
			drive_pins(1'b1, it[0], 1'b0);
			check_core(b0, b1);
			drive_pins(1'b1, ~it[0], 1'b0);
			check_core(b0, b1);
		end
		// burst read steps the pointer from bank0 on to bank1
		bkc_host_master_inst.read_two(`BKC_ADDR_VAR0, `BKC_OFS_BANK0, w, acks);
		check({5'h0, acks}, 8'h00, "burst acks");
		check(w[15:8], b0, "burst bank0");
		check(w[7:0], b1, "burst bank1");
		$display("bank registers done");
		// enable pin off, then back on with a power-up pulse
		drive_pins(1'b0, 1'b1, 1'b0);
		check_core(b0, b1);
		drive_pins(1'b1, 1'b1, 1'b0);
		watch(10, t, p);
		check({7'h0, p}, 8'h01, "power-up pulse");
		check_core(b0, b1);
		// over-voltage: a short spike is blanked, a long one trips
		drive_pins(1'b1, 1'b1, 1'b1);
		watch(15, t, p);
		drive_pins(1'b1, 1'b1, 1'b0);
		watch(30, t, p);
		check({7'h0, t}, 8'h00, "spike trip");
		drive_pins(1'b1, 1'b1, 1'b1);
		watch(40, t, p);
		check({6'h0, ovp_trip, out_on}, 8'h02, "long trip");
		drive_pins(1'b1, 1'b1, 1'b0);
		watch(10, t, p);
		check({7'h0, ovp_trip}, 8'h00, "trip cleared");
		$display("pins done");
		// every slew code, reserved bits written as ones
		for (int k = 0; k < 8; k++) begin
			d = {1'($random(seed)), k[2:0], 4'hB};
			bkc_host_master_inst.write_reg(`BKC_ADDR_VAR0, `BKC_OFS_CTRL, d, acks);
			repeat (12) @(posedge core_clk);
			#1;
			check({7'h0, discharge_en}, {7'h0, d[7]}, "discharge");
			check({5'h0, slew_code}, {5'h0, d[6:4]}, "slew");
		end
		bkc_host_master_inst.read_reg(`BKC_ADDR_VAR0, `BKC_OFS_CTRL, b0, acks);
		check(b0, exp_ctrl(d), "ctrl read");
		$display("control register done");
		// soft reset restores every register
		bkc_host_master_inst.write_reg(`BKC_ADDR_VAR0, `BKC_OFS_CTRL, 8'h04, acks);
		bkc_host_master_inst.read_reg(`BKC_ADDR_VAR0, `BKC_OFS_BANK1, d, acks);
		check(d, `BKC_BANK_RST, "bank1 restored");
		bkc_host_master_inst.read_reg(`BKC_ADDR_VAR0, `BKC_OFS_CTRL, d, acks);
		check(d, 8'h80, "ctrl restored");
		drive_pins(1'b1, 1'b0, 1'b0);
		check_core(`BKC_BANK_RST, `BKC_BANK_RST);
		$display("soft reset done");
		test_done();
	end

endmodule : tb_top
